// ==== core/dfs_pkg.sv ====
// Constants for the drive fault status bank
package dfs_pkg;
  // ----------------------------------------------------------------
  // Parameter addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CODE  = 16'h3c02;
  localparam logic [15:0] ADDR_CLASS = 16'h3c04;
  localparam logic [15:0] ADDR_TIME  = 16'h3c06;
  localparam logic [15:0] ADDR_QUAL  = 16'h3c08;
  localparam logic [15:0] ADDR_FLAGS = 16'h3c20;
  localparam logic [15:0] ADDR_PRST  = 16'h3b0a;
  // ----------------------------------------------------------------
  // Sizes, limits and timing
  // ----------------------------------------------------------------
  localparam int          HIST_DEPTH = 10;
  localparam logic [3:0]  HIST_MAX   = 4'ha;
  localparam logic [31:0] TIME_MAX   = 32'h1fffffff;
  localparam int          CLK_MHZ    = 100;
  localparam int          SEC_US     = 1000000;
  localparam int          PIN_COUNT  = 5;
  // Synchronised pin order
  localparam int PIN_STOA = 0;
  localparam int PIN_STOB = 1;
  localparam int PIN_POSITIVE_LIMIT_SWITCH = 2;
  localparam int PIN_NEGATIVE_LIMIT_SWITCH = 3;
  localparam int PIN_REF  = 4;
  // ----------------------------------------------------------------
  // Fault classes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLS_WARN  = 3'h0;
  localparam logic [2:0] CLS_QSTOP = 3'h1;
  localparam logic [2:0] CLS_QOFF  = 3'h2;
  localparam logic [2:0] CLS_FATAL = 3'h3;
  localparam logic [2:0] CLS_HARD  = 3'h4;
  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int B_LIM = 1, B_TRAV = 2, B_STO = 4, B_SER = 6;
  localparam int B_ETH = 8, B_MODE = 10, B_UNDV = 14, B_OVV = 15;
  localparam int B_OVL = 18, B_SUP = 20, B_HOT = 21, B_STALL = 22;
  localparam int B_STOD = 24, B_NVM = 29, B_START = 30, B_SYS = 31;
  // Fault codes; leading hex digit is the category
  function automatic logic [15:0] dfs_code(input int b);
    case (b)
      B_LIM:   return 16'h1310;
      B_TRAV:  return 16'ha300;
      B_STO:   return 16'h1300;
      B_SER:   return 16'hb100;
      B_ETH:   return 16'hb200;
      B_MODE:  return 16'h1a00;
      B_UNDV:  return 16'h3200;
      B_OVV:   return 16'h3100;
      B_OVL:   return 16'h2300;
      B_SUP:   return 16'h3300;
      B_HOT:   return 16'h4100;
      B_STALL: return 16'ha100;
      B_STOD:  return 16'h1301;
      B_NVM:   return 16'h5100;
      B_START: return 16'h110b;
      B_SYS:   return 16'h6100;
      default: return 16'h1000;
    endcase
  endfunction
endpackage

// ==== core/dfs_fault_bank.sv ====
// Latched fault flags, fault history and parameter read port
// ------------------------------------------------------------------
// Functional notes
// - Each record holds a 32-bit seconds timestamp, saturating at 536870911.
// - Each record holds a 16-bit qualifier, e.g. a parameter address.
// - Category flags are readable as a latched word; 1 means occurred.
// - Every fault code belongs to exactly one flag bit.
// - Bit 1, class 1: limit or reference switch active or line broken.
// - Bit 2, class 1: motor outside permitted travel range.
// - Bit 4, class 3: both safe torque inputs low.
// - Bit 6: serial multidrop fieldbus communication interrupted.
// - Bit 8: Ethernet fieldbus interrupted or bad real-time data.
// - Bit 10, class 2: operating mode processing error, detail in qualifier.
// - Bit 14: DC bus undervoltage, class 2 or 3 by threshold.
// - Bit 15, class 3: DC bus overvoltage.
// - Bit 18, class 3: phase current too high, motor overload.
// - Bit 20: controller supply below minimum.
// - Bit 21, class 3: power stage overheated.
// - Bit 22: motor stall, class configurable.
// - Bit 24, class 4: safe torque inputs disagree.
// - Bit 29, class 3 or 4: nonvolatile memory checksum wrong.
// - Bit 30, class 3 or 4: start-up error, cause in record.
// - Bit 31, class 4: internal system error.
// - Codes are 16 bits; leading hex digit selects the category.
// - Reading the code copies the record to a buffer, advances pointer.
// - Class is 0 to 4: warning, quick stops, fatal, unresettable.
// ------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module dfs_fault_bank
  import dfs_pkg::*;
#(
  parameter int CYCLES_PER_SEC = CLK_MHZ * SEC_US
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Pins, asynchronous; limit inputs read 1 while the switch is healthy
  input  wire logic        safeTorqueInputA,
  input  wire logic        safeTorqueInputB,
  input  wire logic        positiveLimitSwitch,
  input  wire logic        negativeLimitSwitch,
  input  wire logic        referenceSwitch,
  // Fault conditions from drive logic
  input  wire logic        travelRangeErr,
  input  wire logic        serialBusErr,
  input  wire logic        ethBusErr,
  input  wire logic        modeProcErr,
  input  wire logic        dcUnderQuickStop,
  input  wire logic        dcUnderSwitchOff,
  input  wire logic        dcOverVolt,
  input  wire logic        motorOverload,
  input  wire logic        ctrlSupplyLow,
  input  wire logic        stageOverTemp,
  input  wire logic        stallDetect,
  input  wire logic        nvChecksumErr,
  input  wire logic        startupErr,
  input  wire logic        internalErr,
  input  wire logic [15:0] faultQualIn,
  // Configuration
  input  wire logic [2:0]  stallClassCfg,
  input  wire logic        nvFatalCfg,
  input  wire logic        faultResetReq,
  // Parameter read port
  input  wire logic        regRdStb,
  input  wire logic [15:0] regAddr,
  output logic [31:0]      regRdData,
  output logic             regRdAck,
  // Status
  output logic [31:0]      latchedFlags
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] pinS1_q, pinS2_q, pinS3_q, pinF_q, pinF_d;
  logic [PIN_COUNT-1:0] pinRaw;
  assign pinRaw = {referenceSwitch, negativeLimitSwitch,
                   positiveLimitSwitch, safeTorqueInputB, safeTorqueInputA};
  // A bit moves only when the last two stages agree
  always_comb begin
    pinF_d = (pinS2_q & pinS3_q) | (pinF_q & (pinS2_q ^ pinS3_q));
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pinS1_q <= '1;
      pinS2_q <= '1;
      pinS3_q <= '1;
      pinF_q  <= '1;
    end else begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinF_q  <= pinF_d;
    end
  end
  // ----------------------------------------------------------------
  // Operating hours counter
  // ----------------------------------------------------------------
  logic [31:0] preCnt_q, preCnt_d, opSec_q, opSec_d;
  always_comb begin
    preCnt_d = preCnt_q + 32'h1;
    opSec_d  = opSec_q;
    if (preCnt_q == 32'(CYCLES_PER_SEC - 1)) begin
      preCnt_d = 32'h0;
      if (opSec_q != TIME_MAX) begin
        opSec_d = opSec_q + 32'h1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      preCnt_q <= 32'h0;
      opSec_q  <= 32'h0;
    end else begin
      preCnt_q <= preCnt_d;
      opSec_q  <= opSec_d;
    end
  end
  // ----------------------------------------------------------------
  // Cause vector and classes
  // ----------------------------------------------------------------
  logic [31:0] cause, hard;
  logic [2:0]  clsOf [32];
  logic [2:0]  nvCls;
  always_comb begin
    cause = 32'h0;
    cause[B_LIM]   = ~&pinF_q[PIN_REF:PIN_POSITIVE_LIMIT_SWITCH];
    cause[B_TRAV]  = travelRangeErr;
    cause[B_STO]   = ~pinF_q[PIN_STOA] & ~pinF_q[PIN_STOB];
    cause[B_SER]   = serialBusErr;
    cause[B_ETH]   = ethBusErr;
    cause[B_MODE]  = modeProcErr;
    cause[B_UNDV]  = dcUnderQuickStop | dcUnderSwitchOff;
    cause[B_OVV]   = dcOverVolt;
    cause[B_OVL]   = motorOverload;
    cause[B_SUP]   = ctrlSupplyLow;
    cause[B_HOT]   = stageOverTemp;
    cause[B_STALL] = stallDetect;
    cause[B_STOD]  = pinF_q[PIN_STOA] ^ pinF_q[PIN_STOB];
    cause[B_NVM]   = nvChecksumErr;
    cause[B_START] = startupErr;
    cause[B_SYS]   = internalErr;
    nvCls = nvFatalCfg ? CLS_HARD : CLS_FATAL;
    for (int i = 0; i < 32; i++) begin
      clsOf[i] = CLS_WARN;
    end
    clsOf[B_LIM]   = CLS_QSTOP;
    clsOf[B_TRAV]  = CLS_QSTOP;
    clsOf[B_STO]   = CLS_FATAL;
    clsOf[B_MODE]  = CLS_QOFF;
    clsOf[B_UNDV]  = dcUnderSwitchOff ? CLS_FATAL : CLS_QOFF;
    clsOf[B_OVV]   = CLS_FATAL;
    clsOf[B_OVL]   = CLS_FATAL;
    clsOf[B_HOT]   = CLS_FATAL;
    clsOf[B_STALL] = (stallClassCfg > CLS_HARD) ? CLS_HARD
                                                : stallClassCfg;
    clsOf[B_STOD]  = CLS_HARD;
    clsOf[B_NVM]   = nvCls;
    clsOf[B_START] = nvCls;
    clsOf[B_SYS]   = CLS_HARD;
    for (int i = 0; i < 32; i++) begin
      hard[i] = cause[i] & (clsOf[i] == CLS_HARD);
    end
  end
  // ----------------------------------------------------------------
  // Latched flags and history
  // ----------------------------------------------------------------
  logic [31:0] flags_q, flags_d, keep_q, keep_d, fresh;
  logic [15:0] hCode_q [HIST_DEPTH], hCode_d [HIST_DEPTH];
  logic [2:0]  hCls_q  [HIST_DEPTH], hCls_d  [HIST_DEPTH];
  logic [31:0] hTime_q [HIST_DEPTH], hTime_d [HIST_DEPTH];
  logic [15:0] hQual_q [HIST_DEPTH], hQual_d [HIST_DEPTH];
  logic [3:0]  cnt_q, cnt_d, wIdx;
  logic        newFault;
  logic [4:0]  sel;
  logic [15:0] rdBufCode_q, rdBufCode_d, rdBufQual_q, rdBufQual_d;
  logic [2:0]  rdBufCls_q, rdBufCls_d;
  logic [31:0] rdBufTime_q, rdBufTime_d, rdData_d;
  logic [3:0]  rdPtr_q, rdPtr_d;
  logic        codeRd;
  always_comb begin
    // Only a newly raised category is recorded; highest-numbered bit wins
    fresh    = cause & ~flags_q;
    newFault = |fresh;
    sel      = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (fresh[i]) begin
        sel = 5'(i);
      end
    end
    keep_d  = keep_q | hard;
    flags_d = flags_q | cause;
    if (faultResetReq) begin
      // Set beats clear; class 4 bits survive until reset
      flags_d = (flags_q & keep_q) | cause;
    end
    hCode_d = hCode_q;
    hCls_d  = hCls_q;
    hTime_d = hTime_q;
    hQual_d = hQual_q;
    cnt_d   = cnt_q;
    wIdx    = cnt_q;
    if (newFault) begin
      if (cnt_q == HIST_MAX) begin
        // Full: oldest entry drops out at index 0
        for (int i = 0; i < HIST_DEPTH - 1; i++) begin
          hCode_d[i] = hCode_q[i+1];
          hCls_d[i]  = hCls_q[i+1];
          hTime_d[i] = hTime_q[i+1];
          hQual_d[i] = hQual_q[i+1];
        end
        wIdx = HIST_MAX - 4'h1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
      hCode_d[wIdx] = dfs_code(int'(sel));
      hCls_d[wIdx]  = clsOf[sel];
      hTime_d[wIdx] = opSec_q;
      hQual_d[wIdx] = (sel == 5'(B_MODE) || sel == 5'(B_START))
                      ? faultQualIn : 16'h0;
    end
  end
  // ----------------------------------------------------------------
  // Parameter reads
  // ----------------------------------------------------------------
  always_comb begin
    codeRd      = regRdStb && (regAddr == ADDR_CODE);
    rdBufCode_d = rdBufCode_q;
    rdBufCls_d  = rdBufCls_q;
    rdBufTime_d = rdBufTime_q;
    rdBufQual_d = rdBufQual_q;
    rdPtr_d     = rdPtr_q;
    if (regRdStb && regAddr == ADDR_PRST) begin
      rdPtr_d = 4'h0;
    end
    if (codeRd) begin
      // Past the last entry every field reads zero
      rdBufCode_d = 16'h0;
      rdBufCls_d  = CLS_WARN;
      rdBufTime_d = 32'h0;
      rdBufQual_d = 16'h0;
      if (rdPtr_q < cnt_q) begin
        rdBufCode_d = hCode_q[rdPtr_q];
        rdBufCls_d  = hCls_q[rdPtr_q];
        rdBufTime_d = hTime_q[rdPtr_q];
        rdBufQual_d = hQual_q[rdPtr_q];
        rdPtr_d     = rdPtr_q + 4'h1;
      end
    end
    unique case (regAddr)
      ADDR_CODE:  rdData_d = {16'h0, rdBufCode_d};
      ADDR_CLASS: rdData_d = {29'h0, rdBufCls_q};
      ADDR_TIME:  rdData_d = rdBufTime_q;
      ADDR_QUAL:  rdData_d = {16'h0, rdBufQual_q};
      ADDR_FLAGS: rdData_d = flags_q;
      default:    rdData_d = 32'h0;
    endcase
    if (!regRdStb) begin
      rdData_d = regRdData;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flags_q      <= 32'h0;
      keep_q       <= 32'h0;
      cnt_q        <= 4'h0;
      rdPtr_q      <= 4'h0;
      rdBufCode_q  <= 16'h0;
      rdBufCls_q   <= 3'h0;
      rdBufTime_q  <= 32'h0;
      rdBufQual_q  <= 16'h0;
      regRdData    <= 32'h0;
      regRdAck     <= 1'b0;
      latchedFlags <= 32'h0;
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hCode_q[i] <= 16'h0;
        hCls_q[i]  <= 3'h0;
        hTime_q[i] <= 32'h0;
        hQual_q[i] <= 16'h0;
      end
    end else begin
      flags_q      <= flags_d;
      keep_q       <= keep_d;
      cnt_q        <= cnt_d;
      rdPtr_q      <= rdPtr_d;
      rdBufCode_q  <= rdBufCode_d;
      rdBufCls_q   <= rdBufCls_d;
      rdBufTime_q  <= rdBufTime_d;
      rdBufQual_q  <= rdBufQual_d;
      regRdData    <= rdData_d;
      regRdAck     <= regRdStb;
      latchedFlags <= flags_d;
      hCode_q      <= hCode_d;
      hCls_q       <= hCls_d;
      hTime_q      <= hTime_d;
      hQual_q      <= hQual_d;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  flag_sticky_a: assert property (
    !faultResetReq |=> (latchedFlags & $past(latchedFlags))
                        == $past(latchedFlags))
    else $error("latched flag dropped without fault reset");
  hard_keep_a: assert property (
    faultResetReq && latchedFlags[B_STOD] |=> latchedFlags[B_STOD])
    else $error("class 4 flag cleared by fault reset");
  set_wins_a: assert property (
    |cause |=> (latchedFlags & $past(cause)) == $past(cause))
    else $error("fault cause did not latch its flag");
  sto_both_a: assert property (
    (!pinF_q[PIN_STOA] && !pinF_q[PIN_STOB]) |=> latchedFlags[B_STO])
    else $error("both safe torque inputs low but flag clear");
  read_ack_a: assert property (
    regRdAck == $past(regRdStb))
    else $error("read acknowledge does not follow strobe by one cycle");
  flag_read_a: assert property (
    regRdStb && regAddr == ADDR_FLAGS |=> regRdData == $past(flags_q))
    else $error("flag word read returned wrong data");
  ptr_step_a: assert property (
    (codeRd && rdPtr_q < cnt_q && !newFault) |=>
      rdPtr_q == $past(rdPtr_q) + 4'h1 && rdBufCode_q != 16'h0)
    else $error("code read did not advance history pointer");
  time_cap_a: assert property (
    $changed(opSec_q) |-> opSec_q == $past(opSec_q) + 32'h1
                          && opSec_q <= TIME_MAX)
    else $error("operating seconds did not step by one within limit");
  hist_count_a: assert property (
    newFault && cnt_q < HIST_MAX |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("history count did not follow new fault");
endmodule
`default_nettype wire

// ==== tb/dfs_master_model.sv ====
// Fieldbus master model issuing parameter reads to the fault bank
`timescale 1ns/100ps
`default_nettype none
module dfs_master_model (
  // Clock
  input  wire logic        ref_clk,
  // Parameter read port
  output logic             regRdStb,
  output logic [15:0]      regAddr,
  input  wire logic [31:0] regRdData,
  input  wire logic        regRdAck
);
  initial begin
    regRdStb = 1'b0;
    regAddr  = 16'h0000;
  end
  // One strobe cycle per read; a second cycle would count as a new read
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    regRdStb = 1'b1;
    regAddr  = a;
    @(posedge ref_clk);
    #1;
    regRdStb = 1'b0;
    regAddr  = ~a;
    while (regRdAck !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    d = (regRdAck === 1'b1) ? regRdData : 32'hdeadbeef;
  endtask
endmodule
`default_nettype wire

// ==== tb/drive_fault_status_bank_tb.sv ====
// Self-checking bench for the fault status bank
`timescale 1ns/100ps
`default_nettype none
module drive_fault_status_bank_tb;
  import dfs_pkg::*;
  logic        ref_clk, srst, stoA, stoB, positive_limit_switch, negative_limit_switch, refSw;
  logic        nvFatalCfg, faultResetReq, regRdStb, regRdAck;
  logic [13:0] cause;
  logic [15:0] faultQualIn, regAddr;
  logic [2:0]  stallClassCfg;
  logic [31:0] regRdData, latchedFlags, d;
  int          fails, nCompared;
  // Flag bit per cause line
  int bitOf [14] = '{2,6,8,10,14,14,15,18,20,21,22,29,30,31};

  dfs_fault_bank #(.CYCLES_PER_SEC(10)) u_dut (
    .ref_clk(ref_clk), .srst(srst),
    .safeTorqueInputA(stoA), .safeTorqueInputB(stoB),
    .positiveLimitSwitch(positive_limit_switch), .negativeLimitSwitch(negative_limit_switch),
    .referenceSwitch(refSw),
    .travelRangeErr(cause[0]), .serialBusErr(cause[1]),
    .ethBusErr(cause[2]), .modeProcErr(cause[3]),
    .dcUnderQuickStop(cause[4]), .dcUnderSwitchOff(cause[5]),
    .dcOverVolt(cause[6]), .motorOverload(cause[7]),
    .ctrlSupplyLow(cause[8]), .stageOverTemp(cause[9]),
    .stallDetect(cause[10]), .nvChecksumErr(cause[11]),
    .startupErr(cause[12]), .internalErr(cause[13]),
    .faultQualIn(faultQualIn), .stallClassCfg(stallClassCfg),
    .nvFatalCfg(nvFatalCfg), .faultResetReq(faultResetReq),
    .regRdStb(regRdStb), .regAddr(regAddr), .regRdData(regRdData),
    .regRdAck(regRdAck), .latchedFlags(latchedFlags));

  dfs_master_model u_master (
    .ref_clk(ref_clk), .regRdStb(regRdStb), .regAddr(regAddr),
    .regRdData(regRdData), .regRdAck(regRdAck));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    u_master.rd(a, d);
  endtask
  task automatic pulse(input int i);
    cause[i] = 1'b1;
    tick(1);
    cause = '0;
    tick(1);
  endtask
  // Inputs return to healthy idle levels while reset is held
  task automatic do_reset();
    srst = 1'b1;
    {stoA, stoB, positive_limit_switch, negative_limit_switch, refSw} = 5'h1f;
    {cause, faultQualIn, stallClassCfg, nvFatalCfg, faultResetReq} = '0;
    tick(3);
    srst = 1'b0;
  endtask
  task automatic clear_req();
    faultResetReq = 1'b1;
    tick(1);
    faultResetReq = 1'b0;
    tick(3);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic test_idle();
    do_reset();
    check(latchedFlags, 32'h0);
    rd(ADDR_CODE);
    check(d, 32'h0);
    rd(16'h1234);
    check(d, 32'h0);
    rd(ADDR_FLAGS);
    check(d, 32'h0);
    $display("test idle done");
  endtask
  task automatic test_flags();
    do_reset();
    faultQualIn = 16'h3c0a;
    for (int i = 0; i < 13; i++) begin
      pulse(i);
      tick(2);
      check(latchedFlags, 32'h1 << bitOf[i]);
      rd(ADDR_FLAGS);
      check(d, 32'h1 << bitOf[i]);
      clear_req();
      check(latchedFlags, 32'h0);
    end
    // Thirteen records went in; the three oldest have dropped out
    rd(ADDR_PRST);
    rd(ADDR_CODE);
    check(d, 32'h1a00);
    rd(ADDR_QUAL);
    check(d, 32'h3c0a);
    rd(ADDR_CLASS);
    check(d, 32'h2);
    rd(ADDR_CODE);
    rd(ADDR_CLASS);
    check(d, 32'h2);
    rd(ADDR_QUAL);
    check(d, 32'h0);
    rd(ADDR_CODE);
    rd(ADDR_CLASS);
    check(d, 32'h3);
    $display("test flags done");
  endtask
  task automatic test_record();
    do_reset();
    tick(30);
    pulse(7);
    faultQualIn = 16'h3c0a;
    pulse(12);
    faultQualIn = 16'h0000;
    tick(2);
    rd(ADDR_FLAGS);
    check(d, 32'h40040000);
    for (int k = 0; k < 2; k++) begin
      rd(ADDR_PRST);
      rd(ADDR_CODE);
      check(d, 32'h2300);
    end
    rd(ADDR_CLASS);
    check(d, 32'h3);
    rd(ADDR_TIME);
    check(d >= 2 && d <= 4, 1'b1);
    rd(ADDR_QUAL);
    check(d, 32'h0);
    rd(ADDR_CODE);
    check(d, 32'h110b);
    rd(ADDR_QUAL);
    check(d, 32'h3c0a);
    rd(ADDR_CODE);
    check(d, 32'h0);
    $display("test record done");
  endtask
  task automatic test_class4();
    do_reset();
    nvFatalCfg = 1'b1;
    stallClassCfg = 3'h6;
    pulse(11);
    pulse(10);
    pulse(13);
    tick(2);
    clear_req();
    check(latchedFlags, 32'ha0400000);
    rd(ADDR_PRST);
    for (int k = 0; k < 3; k++) begin
      rd(ADDR_CODE);
      rd(ADDR_CLASS);
      check(d, 32'h4);
    end
    $display("test class4 done");
  endtask
  task automatic test_sto();
    do_reset();
    stoA = 1'b0;
    tick(8);
    check(latchedFlags, 32'h01000000);
    stoB = 1'b0;
    tick(8);
    check(latchedFlags, 32'h01000010);
    {stoA, stoB} = 2'h3;
    tick(8);
    clear_req();
    check(latchedFlags, 32'h01000000);
    rd(ADDR_PRST);
    rd(ADDR_CODE);
    check(d, 32'h1301);
    rd(ADDR_CLASS);
    check(d, 32'h4);
    rd(ADDR_CODE);
    check(d, 32'h1300);
    rd(ADDR_CLASS);
    check(d, 32'h3);
    $display("test sto done");
  endtask
  task automatic test_limit();
    do_reset();
    negative_limit_switch = 1'b0;
    tick(8);
    negative_limit_switch = 1'b1;
    tick(8);
    check(latchedFlags, 32'h2);
    rd(ADDR_PRST);
    rd(ADDR_CODE);
    rd(ADDR_CLASS);
    check(d, 32'h1);
    clear_req();
    refSw = 1'b0;
    tick(8);
    refSw = 1'b1;
    positive_limit_switch = 1'b0;
    tick(8);
    check(latchedFlags, 32'h2);
    $display("test limit done");
  endtask

  initial begin
    fails = 0;
    nCompared = 0;
    srst = 1'b1;
    {stoA, stoB, positive_limit_switch, negative_limit_switch, refSw} = 5'h1f;
    {cause, faultQualIn, stallClassCfg, nvFatalCfg, faultResetReq} = '0;
    test_idle();
    test_flags();
    test_record();
    test_class4();
    test_sto();
    test_limit();
    finish_test();
  end
  // Whole run needs about 340 cycles
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
